// ==== core/rtv_trip_voter.sv ====
// Purpose: two-out-of-three trip voting for one irradiation_unit
// Assumes: sensor words and mode come from pins and are synchronised here
// Notes:   outputs are levels; seal-in belongs to the actuation logic downstream
`timescale 1ns/1ps
module rtv_trip_voter #(
    parameter logic [rtv_pkg::TMR_W-1:0] P_COOL_DELAY_CYC = rtv_pkg::COOL_DELAY_CYC,
    parameter logic [rtv_pkg::TMR_W-1:0] P_FLUX_DELAY_CYC = rtv_pkg::FLUX_DELAY_CYC
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_b,
    input  wire logic [2:0]                i_mode,
    input  wire logic [rtv_pkg::DATA_W-1:0] i_src_flux  [rtv_pkg::CHAN],
    input  wire logic [rtv_pkg::DATA_W-1:0] i_pwr_flux  [rtv_pkg::CHAN],
    input  wire logic [rtv_pkg::DATA_W-1:0] i_wide_flux [rtv_pkg::CHAN],
    input  wire logic [rtv_pkg::DATA_W-1:0] i_loop_temp [rtv_pkg::CHAN],
    input  wire logic [rtv_pkg::DATA_W-1:0] i_loop_flow [rtv_pkg::CHAN],
    output logic                           o_cell_safety_act,
    output logic                           o_driver_dropout,
    output logic                           o_power_permissive,
    output logic [7:0]                     o_function_trip
);
    import rtv_pkg::*;

    // =====================================================================
    // input synchronisers: every pin word passes two flops
    logic [2:0]        mode_s1;
    logic [2:0]        mode_s2;
    logic [DATA_W-1:0] src_s1  [CHAN];
    logic [DATA_W-1:0] src_s2  [CHAN];
    logic [DATA_W-1:0] pwr_s1  [CHAN];
    logic [DATA_W-1:0] pwr_s2  [CHAN];
    logic [DATA_W-1:0] wide_s1 [CHAN];
    logic [DATA_W-1:0] wide_s2 [CHAN];
    logic [DATA_W-1:0] temp_s1 [CHAN];
    logic [DATA_W-1:0] temp_s2 [CHAN];
    logic [DATA_W-1:0] flow_s1 [CHAN];
    logic [DATA_W-1:0] flow_s2 [CHAN];

    // mode sync
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_s1 <= 3'h0;
            mode_s2 <= 3'h0;
        end else begin
            mode_s1 <= i_mode;
            mode_s2 <= mode_s1;
        end
    end

    // =====================================================================
    // time-average sample strobe: one-cycle enable from a divider
    logic [7:0]          samp_div;
    logic [AVG_LOG2-1:0] samp_idx;
    wire                 samp_en   = (samp_div == AVG_SAMPLE_CYC - 8'h01);
    wire                 win_close = samp_en && (samp_idx == '1);

    // sample divider and window index
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            samp_div <= 8'h00;
            samp_idx <= '0;
        end else if (samp_en) begin
            samp_div <= 8'h00;
            samp_idx <= samp_idx + AVG_LOG2'(1);
        end else begin
            samp_div <= samp_div + 8'h01;
        end
    end

    // =====================================================================
    // per-channel sync, averaging and setpoint comparisons
    logic [CHAN-1:0] src_trip;
    logic [CHAN-1:0] pwr_low_trip;
    logic [CHAN-1:0] pwr_permit;
    logic [CHAN-1:0] tavg_trip;
    logic [CHAN-1:0] wide_trip;
    logic [CHAN-1:0] hot_trip;
    logic [CHAN-1:0] cold_trip;
    logic [CHAN-1:0] flow_trip;

    genvar ch;
    generate
        for (ch = 0; ch < CHAN; ch++) begin : g_chan
            logic [DATA_W+AVG_LOG2-1:0] acc;
            logic [DATA_W-1:0]          avg;
            wire  [DATA_W+AVG_LOG2-1:0] acc_next = acc + (DATA_W+AVG_LOG2)'(pwr_s2[ch]);

            // two-flop sync of the sensor words
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    src_s1[ch]  <= '0;
                    src_s2[ch]  <= '0;
                    pwr_s1[ch]  <= '0;
                    pwr_s2[ch]  <= '0;
                    wide_s1[ch] <= '0;
                    wide_s2[ch] <= '0;
                    temp_s1[ch] <= '0;
                    temp_s2[ch] <= '0;
                    flow_s1[ch] <= '0;
                    flow_s2[ch] <= '0;
                end else begin
                    src_s1[ch]  <= i_src_flux[ch];
                    src_s2[ch]  <= src_s1[ch];
                    pwr_s1[ch]  <= i_pwr_flux[ch];
                    pwr_s2[ch]  <= pwr_s1[ch];
                    wide_s1[ch] <= i_wide_flux[ch];
                    wide_s2[ch] <= wide_s1[ch];
                    temp_s1[ch] <= i_loop_temp[ch];
                    temp_s2[ch] <= temp_s1[ch];
                    flow_s1[ch] <= i_loop_flow[ch];
                    flow_s2[ch] <= flow_s1[ch];
                end
            end

            // block average over one window; holds between window ends
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    acc <= '0;
                    avg <= '0;
                end else if (win_close) begin
                    acc <= '0;
                    avg <= acc_next[DATA_W+AVG_LOG2-1:AVG_LOG2];
                end else if (samp_en) begin
                    acc <= acc_next;
                end
            end

            // comparisons; a zero reading after reset trips the low ones,
            // which is harmless because they are bypassed outside modes 1 and 2
            assign src_trip[ch]     = src_s2[ch]  > SRC_HIGH_SP;
            assign pwr_low_trip[ch] = pwr_s2[ch]  < PWR_LOW_SP;
            assign pwr_permit[ch]   = pwr_s2[ch] >= PWR_PERMIT_SP;
            assign tavg_trip[ch]    = avg         > TAVG_HIGH_SP;
            assign wide_trip[ch]    = wide_s2[ch] > WIDE_HIGH_SP;
            assign hot_trip[ch]     = temp_s2[ch] > TEMP_HIGH_SP;
            assign cold_trip[ch]    = temp_s2[ch] < TEMP_LOW_SP;
            assign flow_trip[ch]    = flow_s2[ch] < FLOW_LOW_SP;
        end
    endgenerate

    // two-out-of-three majority
    function automatic logic vote2of3(input logic [CHAN-1:0] t);
        vote2of3 = (t[0] & t[1]) | (t[0] & t[2]) | (t[1] & t[2]);
    endfunction : vote2of3

    // =====================================================================
    // mode decode and bypasses
    rtv_mode_type mode;
    logic         power_permissive;
    assign mode = rtv_mode_type'(mode_s2);

    wire src_mode_ok  = !(mode == MODE_IRRAD || mode == MODE_POST || mode == MODE_TRANSFER);
    wire irrad_mode   = (mode == MODE_IRRAD);
    wire cool_mode_ok = (mode == MODE_FILL || mode == MODE_IRRAD);

    // coincidence votes, evaluated every cycle
    wire src_vote    = vote2of3(src_trip);
    wire pwr_vote    = vote2of3(pwr_low_trip);
    wire permit_vote = vote2of3(pwr_permit);
    wire tavg_vote   = vote2of3(tavg_trip);
    wire wide_vote   = vote2of3(wide_trip);
    wire hot_vote    = vote2of3(hot_trip);
    wire cold_vote   = vote2of3(cold_trip);
    wire flow_vote   = vote2of3(flow_trip);

    // gated functions; timers only run while their trip is enabled
    wire src_act  = src_vote && src_mode_ok;
    wire lpf_run  = pwr_vote && irrad_mode && power_permissive;
    wire hot_run  = hot_vote && cool_mode_ok;
    wire cold_act = cold_vote && cool_mode_ok;
    wire flow_run = flow_vote && cool_mode_ok;

    // permissive arms once power reaches its level in irradiation, drops on leaving it
    wire next_power_permissive = irrad_mode && (power_permissive || permit_vote);

    // =====================================================================
    // delay timers
    logic lpf_expired;
    logic hot_expired;
    logic flow_expired;

    rtv_delay_timer u_lpf_timer (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_run     (lpf_run),
        .i_limit   (P_FLUX_DELAY_CYC),
        .o_expired (lpf_expired)
    );

    // both cooling timers carry the three-minute loss-of-cooling allowance
    rtv_delay_timer u_hot_timer (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_run     (hot_run),
        .i_limit   (P_COOL_DELAY_CYC),
        .o_expired (hot_expired)
    );

    rtv_delay_timer u_flow_timer (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_run     (flow_run),
        .i_limit   (P_COOL_DELAY_CYC),
        .o_expired (flow_expired)
    );

    // =====================================================================
    // actuation combine
    wire next_cell_safety_act = src_act | tavg_vote | wide_vote | hot_expired | cold_act | flow_expired;
    wire next_driver_dropout  = lpf_expired;
    wire [7:0] next_function_trip = {flow_expired, cold_act, hot_expired, wide_vote,
                                     tavg_vote, lpf_expired, src_act, power_permissive};

    // registered outputs
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            power_permissive   <= 1'b0;
            o_power_permissive <= 1'b0;
            o_cell_safety_act  <= 1'b0;
            o_driver_dropout   <= 1'b0;
            o_function_trip    <= 8'h00;
        end else begin
            power_permissive   <= next_power_permissive;
            o_power_permissive <= next_power_permissive;
            o_cell_safety_act  <= next_cell_safety_act;
            o_driver_dropout   <= next_driver_dropout;
            o_function_trip    <= next_function_trip;
        end
    end

    // =====================================================================
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    chk_src_actuates: assert property (src_vote && src_mode_ok |=> o_cell_safety_act)
        else $error("source flux coincidence did not actuate");
    chk_src_bypass: assert property (!src_mode_ok |=> !o_function_trip[1])
        else $error("source flux acted in a bypassed mode");
    chk_lpf_mode: assert property (!irrad_mode |-> !lpf_run ##1 !o_driver_dropout)
        else $error("low power flux active outside irradiation");
    chk_lpf_permit: assert property (!power_permissive |=> !o_driver_dropout)
        else $error("dropout without the power permissive");
    chk_lpf_dropout: assert property ($rose(o_driver_dropout) |-> $past(lpf_run, 2))
        else $error("dropout without a running timer");
    chk_lpf_reset: assert property (!pwr_vote |=> !lpf_expired ##1 !o_driver_dropout)
        else $error("dropout survived loss of coincidence");
    chk_tavg_act: assert property (tavg_vote |=> o_cell_safety_act)
        else $error("averaged flux coincidence did not actuate");
    chk_wide_act: assert property (wide_vote |=> o_cell_safety_act && o_function_trip[4])
        else $error("wide flux coincidence did not actuate");
    chk_hot_bypass: assert property (!cool_mode_ok |=> !hot_expired && !flow_expired)
        else $error("cooling timer expired in a bypassed mode");
    chk_cold_act: assert property (cold_vote && cool_mode_ok |=> o_cell_safety_act && o_function_trip[6])
        else $error("low temperature coincidence did not actuate at once");

endmodule : rtv_trip_voter

// ==== core/rtv_pkg.sv ====
// Purpose: shared constants for the trip voting block of one irradiation_unit
// Assumes: 250 MHz clock, three protection channels, 16-bit unsigned sensor words
// Notes:   setpoints and delays are configuration constants, fixed at build time
package rtv_pkg;

    // =====================================================================
    // structure
    localparam int CHAN   = 3;
    localparam int DATA_W = 16;
    localparam int TMR_W  = 40;
    localparam int AVG_LOG2 = 4;                 // 16 samples per averaging window

    // operating modes of the irradiation_unit
    typedef enum logic [2:0] {
        MODE_EMPTY    = 3'b000,
        MODE_FILL     = 3'b001,
        MODE_IRRAD    = 3'b010,
        MODE_POST     = 3'b011,
        MODE_TRANSFER = 3'b100
    } rtv_mode_type;

    // =====================================================================
    // setpoints, unsigned sensor counts
    localparam logic [DATA_W-1:0] SRC_HIGH_SP   = 16'hc000;
    localparam logic [DATA_W-1:0] PWR_LOW_SP    = 16'h0800;
    localparam logic [DATA_W-1:0] PWR_PERMIT_SP = 16'h1000;
    localparam logic [DATA_W-1:0] TAVG_HIGH_SP  = 16'hd000;
    localparam logic [DATA_W-1:0] WIDE_HIGH_SP  = 16'he000;
    localparam logic [DATA_W-1:0] TEMP_HIGH_SP  = 16'hb000;
    localparam logic [DATA_W-1:0] TEMP_LOW_SP   = 16'h2000;
    localparam logic [DATA_W-1:0] FLOW_LOW_SP   = 16'h3000;

    // =====================================================================
    // timing
    localparam longint CLK_HZ            = 250_000_000;
    localparam longint LOSS_OF_COOL_MIN  = 3;     // tolerated total loss of cooling
    localparam longint FLUX_DELAY_MS     = 100;   // low power flux dropout delay
    localparam longint AVG_SAMPLE_NS     = 1000;  // spacing of averaging samples
    localparam logic [TMR_W-1:0] COOL_DELAY_CYC = TMR_W'(LOSS_OF_COOL_MIN * 60 * CLK_HZ);
    localparam logic [TMR_W-1:0] FLUX_DELAY_CYC = TMR_W'(FLUX_DELAY_MS * CLK_HZ / 1000);
    localparam logic [7:0]       AVG_SAMPLE_CYC = 8'(AVG_SAMPLE_NS * CLK_HZ / 1_000_000_000);

endpackage : rtv_pkg

// ==== core/rtv_delay_timer.sv ====
// Purpose: coincidence delay timer, runs while its trip stays voted
// Assumes: i_run and i_limit come from logic on the same clock
// Notes:   any drop of i_run clears the count at once, no partial credit kept
`timescale 1ns/1ps
module rtv_delay_timer (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_b,
    input  wire logic                     i_run,
    input  wire logic [rtv_pkg::TMR_W-1:0] i_limit,
    output logic                          o_expired
);
    import rtv_pkg::*;

    logic [TMR_W-1:0] count;
    wire              at_limit = (count == i_limit);

    // =====================================================================
    // counter: cleared whenever coincidence or enable is lost
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count <= '0;
        end else if (!i_run) begin
            count <= '0;
        end else if (!at_limit) begin
            count <= count + TMR_W'(1);
        end
    end

    // expiry is a level that holds while the trip stays voted
    assign o_expired = i_run && at_limit;

    // =====================================================================
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    chk_timer_clear: assert property (!i_run |=> count == '0 && !o_expired)
        else $error("timer not cleared after run dropped");
    chk_timer_full: assert property ($rose(o_expired) |-> $past(count) == i_limit - TMR_W'(1))
        else $error("timer expired before its full length");

endmodule : rtv_delay_timer

// ==== testbench/rtv_sensor_model.sv ====
// Purpose: flux and cooling loop sensor model, three division channels per variable
// Assumes: the bench calls set_var and nominal just after a falling clock edge
// Notes:   a word holds until changed, as a live transmitter would; no handshake exists
`timescale 1ns/1ps
module rtv_sensor_model (
    output logic [rtv_pkg::DATA_W-1:0] o_src  [rtv_pkg::CHAN],
    output logic [rtv_pkg::DATA_W-1:0] o_pwr  [rtv_pkg::CHAN],
    output logic [rtv_pkg::DATA_W-1:0] o_wide [rtv_pkg::CHAN],
    output logic [rtv_pkg::DATA_W-1:0] o_temp [rtv_pkg::CHAN],
    output logic [rtv_pkg::DATA_W-1:0] o_flow [rtv_pkg::CHAN]
);
    import rtv_pkg::*;

    // =====================================================================
    // storage, index 0 src, 1 pwr, 2 wide, 3 temp, 4 flow
    logic [DATA_W-1:0] word [5][CHAN];

    // each variable leaves on its own three channels, one per division
    assign o_src  = word[0];
    assign o_pwr  = word[1];
    assign o_wide = word[2];
    assign o_temp = word[3];
    assign o_flow = word[4];

    // quiet plant: pwr above permissive so mode 2 arms, cooling well inside limits
    task automatic nominal;
        for (int c = 0; c < CHAN; c++) begin
            word[0][c] = 16'h1000;
            word[1][c] = 16'h2000;
            word[2][c] = 16'h1000;
            word[3][c] = 16'h6000;
            word[4][c] = 16'h8000;
        end
    endtask : nominal

    // set the channels in the mask; the others keep their value
    task automatic set_var(input int v, input logic [2:0] mask, input logic [DATA_W-1:0] val);
        for (int c = 0; c < CHAN; c++) begin
            if (mask[c]) word[v][c] = val;
        end
    endtask : set_var

    initial begin
        nominal();
    end
endmodule : rtv_sensor_model

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench for the trip voter
// Assumes: short timer limits, inputs change on falling edges
// Notes:   untimed answers are checked 5 cycles after a change, above the 3-edge latency
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
    import rtv_pkg::*;
    localparam int COOL_L = 20;
    localparam int FLUX_L = 10;
    localparam int V_PWR  = 1;
    localparam int V_SRC  = 0;
    localparam int V_WIDE = 2;
    localparam int V_TEMP = 3;
    localparam int V_FLOW = 4;

    logic              i_clk;
    logic              i_rst_b;
    logic [2:0]        i_mode;
    logic [DATA_W-1:0] src  [CHAN];
    logic [DATA_W-1:0] pwr  [CHAN];
    logic [DATA_W-1:0] wide [CHAN];
    logic [DATA_W-1:0] temp [CHAN];
    logic [DATA_W-1:0] flow [CHAN];
    logic              o_cell_safety_act;
    logic              o_driver_dropout;
    logic              o_power_permissive;
    logic [7:0]        o_function_trip;
    int                mismatches = 0;
    int                checks_done = 0;

    rtv_sensor_model u_sens (.o_src(src), .o_pwr(pwr), .o_wide(wide), .o_temp(temp), .o_flow(flow));

    rtv_trip_voter #(
        .P_COOL_DELAY_CYC (TMR_W'(COOL_L)),
        .P_FLUX_DELAY_CYC (TMR_W'(FLUX_L))
    ) u_dut (
        .i_clk (i_clk), .i_rst_b (i_rst_b), .i_mode (i_mode),
        .i_src_flux (src), .i_pwr_flux (pwr), .i_wide_flux (wide), .i_loop_temp (temp), .i_loop_flow (flow),
        .o_cell_safety_act (o_cell_safety_act), .o_driver_dropout (o_driver_dropout),
        .o_power_permissive (o_power_permissive), .o_function_trip (o_function_trip)
    );

    // =====================================================================
    // helpers
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : wait_cyc

    task automatic report_and_stop;
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // =====================================================================
    // scenarios
    // every mode code, two channels just over the setpoint, then one at the setpoint
    task automatic t_src;
        logic exp;
        for (int m = 0; m < 8; m++) begin
            i_mode = 3'(m);
            u_sens.set_var(V_SRC, 3'b101, 16'hc001);
            wait_cyc(5);
            exp = !(m inside {2, 3, 4});
            `CHK("src act", exp, o_cell_safety_act)
            `CHK("src vote", exp, o_function_trip[1])
            u_sens.set_var(V_SRC, 3'b100, 16'hc000);
            wait_cyc(5);
            `CHK("src at setpoint", 1'b0, o_function_trip[1])
            u_sens.nominal();
        end
    endtask : t_src

    task automatic t_wide;
        i_mode = 3'h3;
        u_sens.set_var(V_WIDE, 3'b011, 16'he001);
        wait_cyc(5);
        `CHK("wide act", 1'b1, o_cell_safety_act)
        `CHK("wide vote", 1'b1, o_function_trip[4])
        u_sens.set_var(V_WIDE, 3'b001, 16'he000);
        wait_cyc(5);
        `CHK("wide one", 1'b0, o_function_trip[4])
        u_sens.nominal();
    endtask : t_wide

    // no timer: the answer must come inside the untimed latency
    task automatic t_low_temp;
        logic exp;
        for (int m = 0; m < 5; m++) begin
            i_mode = 3'(m);
            u_sens.set_var(V_TEMP, 3'b110, 16'h1fff);
            wait_cyc(5);
            exp = (m == 1 || m == 2);
            `CHK("low temp act", exp, o_cell_safety_act)
            `CHK("low temp vote", exp, o_function_trip[6])
            u_sens.set_var(V_TEMP, 3'b010, 16'h2000);
            wait_cyc(5);
            `CHK("low temp limit", 1'b0, o_function_trip[6])
            u_sens.nominal();
        end
    endtask : t_low_temp

    // expiry only after lim cycles, a one-cycle loss of coincidence restarts, bypass holds clear
    task automatic t_timed(input int v, input logic [15:0] val, input int b, input int lim,
                           input logic [2:0] on_mode, input logic [2:0] off_mode, input bit drop);
        i_mode = on_mode;
        wait_cyc(4);
        u_sens.set_var(v, 3'b011, val);
        wait_cyc(lim - 1);
        `CHK("timer early", 1'b0, o_function_trip[b])
        wait_cyc(6);
        `CHK("timer expired", 1'b1, o_function_trip[b])
        `CHK("timer output", 1'b1, drop ? o_driver_dropout : o_cell_safety_act)
        u_sens.nominal();
        wait_cyc(5);
        `CHK("timer cleared", 1'b0, o_function_trip[b])
        u_sens.set_var(v, 3'b110, val);
        wait_cyc(lim - 3);
        u_sens.nominal();
        wait_cyc(1);
        u_sens.set_var(v, 3'b110, val);
        wait_cyc(lim - 3);
        `CHK("timer restarted", 1'b0, o_function_trip[b])
        wait_cyc(8);
        `CHK("timer after restart", 1'b1, o_function_trip[b])
        u_sens.nominal();
        i_mode = off_mode;
        wait_cyc(4);
        u_sens.set_var(v, 3'b111, val);
        wait_cyc(2 * lim + 6);
        `CHK("timer bypassed", 1'b0, o_function_trip[b])
        u_sens.nominal();
        wait_cyc(4);
    endtask : t_timed

    // low power stays bypassed in mode 2 until the permissive level has been reached
    task automatic t_low_pwr;
        i_mode = 3'h0;
        u_sens.set_var(V_PWR, 3'b111, 16'h07ff);
        wait_cyc(5);
        i_mode = 3'h2;
        wait_cyc(3 * FLUX_L);
        `CHK("no permissive", 1'b0, o_power_permissive)
        `CHK("no dropout", 1'b0, o_driver_dropout)
        u_sens.nominal();
        wait_cyc(5);
        `CHK("permissive", 1'b1, o_power_permissive)
        `CHK("permissive bit", 1'b1, o_function_trip[0])
        t_timed(V_PWR, 16'h07ff, 2, FLUX_L, 3'h2, 3'h1, 1'b1);
        `CHK("permissive off", 1'b0, o_power_permissive)
    endtask : t_low_pwr

    // averaging window is 16 samples 250 cycles apart, so two windows settle it
    task automatic t_avg;
        i_mode = 3'h0;
        u_sens.set_var(V_PWR, 3'b101, 16'hd100);
        wait_cyc(8500);
        `CHK("avg vote", 1'b1, o_function_trip[3])
        `CHK("avg act", 1'b1, o_cell_safety_act)
        u_sens.nominal();
        wait_cyc(8500);
        `CHK("avg clear", 1'b0, o_function_trip[3])
    endtask : t_avg

    // =====================================================================
    // clock, watchdog and main sequence
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // the whole run needs about 17500 cycles
    initial begin
        repeat (40000) @(posedge i_clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        i_rst_b = 1'b0;
        i_mode = 3'h0;
        wait_cyc(2);
        `CHK("reset act", 1'b0, o_cell_safety_act)
        `CHK("reset trips", 8'h00, o_function_trip)
        i_rst_b = 1'b1;
        wait_cyc(5);
        t_src();
        t_wide();
        t_low_temp();
        t_timed(V_TEMP, 16'hb001, 5, COOL_L, 3'h1, 3'h3, 1'b0);
        t_timed(V_FLOW, 16'h2fff, 7, COOL_L, 3'h2, 3'h4, 1'b0);
        t_low_pwr();
        t_avg();
        report_and_stop();
    end
endmodule : testbench
